// >>> logic/ctsr_regs.sv
// calibration averaging, status, trigger source and status pin registers
// What this block does
// - a three-bit offset averaging depth resets to six; larger means more averaging.
// - a three-bit linearity averaging depth resets to one; larger means more averaging.
// - the status register is read-only and carries a code, a stopped flag and a done flag.
// - the stopped flag sets when background calibration halts and clears when it resumes.
// - with background calibration off, stopped sets once foreground finishes or is skipped.
// - the foreground done flag sets when foreground calibration finishes or is skipped.
// - a two-bit selector drives the status pin: done, stopped, alarm or held low.
// - with trigger source at zero the software bit is the trigger and the pin is ignored.
// - with trigger source at one the pin is the trigger and the software bit is ignored.
// - a writable software trigger bit resets to one and stands in for the pin.
// - in trigger-driven low power, a low trigger wakes and a high trigger sleeps.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module ctsr_regs
    import ctsr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [2:0] eng_status_code,
    input  wire logic       eng_fg_finished,
    input  wire logic       eng_fg_skipped,
    input  wire logic       eng_bg_enabled,
    input  wire logic       eng_bg_halted,
    input  wire logic       eng_bg_resumed,
    input  wire logic       eng_restart,
    input  wire logic       alarm_in,
    input  wire logic       lp_trigger_mode,
    input  wire logic       trigger_input_pin,
    output logic            status_output_pin,
    output logic            calibration_trigger,
    output logic            converter_sleep,
    output logic      [2:0] offset_averaging_depth,
    output logic      [2:0] linearity_averaging_depth,
    output logic            irq
);
    logic [7:0] averaging_reg;
    logic [7:0] pin_config_reg;
    logic [7:0] soft_trig_reg;
    logic [2:0] status_code_reg;
    logic       foreground_finished_flag_reg;
    logic       stopped_reg;
    logic       alarm_prev_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic       trig_pin_sync;
    logic       fg_event;
    logic       stop_event;
    logic [2:0] irq_events;
    logic       trigger_next;
    logic       status_pin_next;
    ctsr_pin_sel_t pin_sel;

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    ctsr_sync #(
        .WIDTH    (1)
    ) u_trig_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in (trigger_input_pin),
        .sync_out (trig_pin_sync)
    );

    // address match helper, shared by write and read decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // ****************************************************************
    // writable configuration registers
    // ****************************************************************
    // whole bytes are stored, except the three-bit irq mask, so reserved bits read back what was written
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            averaging_reg  <= CTSR_RST_AVERAGING;
            pin_config_reg <= CTSR_RST_PIN_CONFIG;
            soft_trig_reg  <= CTSR_RST_SOFT_TRIG;
            irq_mask_reg   <= CTSR_RST_IRQ_MASK;
        end
        else if (clk_en && reg_wr)
        begin
            if (hit(reg_addr, CTSR_ADDR_AVERAGING))
                averaging_reg <= reg_wdata;
            if (hit(reg_addr, CTSR_ADDR_PIN_CONFIG))
                pin_config_reg <= reg_wdata;
            if (hit(reg_addr, CTSR_ADDR_SOFT_TRIG))
                soft_trig_reg <= reg_wdata;
            if (hit(reg_addr, CTSR_ADDR_IRQ_MASK))
                irq_mask_reg <= reg_wdata[2:0];
        end
    end

    assign offset_averaging_depth    = averaging_reg[CTSR_OFS_AVG_MSB:CTSR_OFS_AVG_LSB];
    assign linearity_averaging_depth = averaging_reg[CTSR_LIN_AVG_MSB:CTSR_LIN_AVG_LSB];

    // ****************************************************************
    // calibration status flags
    // ****************************************************************
    // flags are set by the engine only; bus writes never reach them
    assign fg_event   = eng_fg_finished || eng_fg_skipped;
    assign stop_event = eng_bg_halted || (!eng_bg_enabled && fg_event);

    // foreground done: restart clears, completion wins over a restart
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            foreground_finished_flag_reg <= 1'b0;
        else if (clk_en)
        begin
            if (fg_event)
                foreground_finished_flag_reg <= 1'b1;
            else if (eng_restart)
                foreground_finished_flag_reg <= 1'b0;
        end
    end

    // stopped: halt or foreground end without background sets it, resume clears
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stopped_reg <= 1'b0;
        else if (clk_en)
        begin
            if (stop_event)
                stopped_reg <= 1'b1;
            else if (eng_bg_resumed || eng_restart)
                stopped_reg <= 1'b0;
        end
    end

    // status code is sampled from the engine every cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            status_code_reg <= 3'h0;
        else if (clk_en)
            status_code_reg <= eng_status_code;
    end

    // ****************************************************************
    // trigger source and status pin multiplexers
    // ****************************************************************
    assign pin_sel      = ctsr_pin_sel_t'(pin_config_reg[CTSR_SEL_MSB:CTSR_SEL_LSB]);
    assign trigger_next = pin_config_reg[CTSR_TRIG_SRC_BIT] ? trig_pin_sync
                                                            : soft_trig_reg[CTSR_SOFT_TRIG_BIT];

    always_comb
    begin
        case (pin_sel)
            CTSR_PIN_FOREGROUND_FINISHED_FLAG: status_pin_next = foreground_finished_flag_reg;
            CTSR_PIN_STOPPED: status_pin_next = stopped_reg;
            CTSR_PIN_ALARM:   status_pin_next = alarm_in;
            CTSR_PIN_LOW:     status_pin_next = 1'b0;
            default:          status_pin_next = 1'b0;
        endcase
    end

    // outputs registered once so a select change shows on the next edge
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            calibration_trigger <= 1'b1;   // software bit resets high
            status_output_pin   <= 1'b0;
        end
        else if (clk_en)
        begin
            calibration_trigger <= trigger_next;
            status_output_pin   <= status_pin_next;
        end
    end

    // low power: the offline converter sleeps while the trigger is high
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            converter_sleep <= 1'b0;
        else if (clk_en)
            converter_sleep <= lp_trigger_mode && trigger_next;
    end

    // ****************************************************************
    // interrupt status and output
    // ****************************************************************
    assign irq_events = {alarm_in && !alarm_prev_reg,
                         stop_event && !stopped_reg,
                         fg_event && !foreground_finished_flag_reg};

    // sticky bits, write one to clear, a new event wins over the clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            alarm_prev_reg <= 1'b0;
            irq_status_reg <= 3'h0;
        end
        else if (clk_en)
        begin
            alarm_prev_reg <= alarm_in;
            if (reg_wr && hit(reg_addr, CTSR_ADDR_IRQ_STATUS))
                irq_status_reg <= (irq_status_reg & ~reg_wdata[2:0]) | irq_events;
            else
                irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(irq_status_reg & irq_mask_reg);
    end

    // ****************************************************************
    // register read port
    // ****************************************************************
    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            if (!reg_rd)
                reg_rdata <= 8'h00;
            else if (hit(reg_addr, CTSR_ADDR_AVERAGING))
                reg_rdata <= averaging_reg;
            else if (hit(reg_addr, CTSR_ADDR_STATUS))
                reg_rdata <= {3'h0, status_code_reg, stopped_reg, foreground_finished_flag_reg};
            else if (hit(reg_addr, CTSR_ADDR_PIN_CONFIG))
                reg_rdata <= pin_config_reg;
            else if (hit(reg_addr, CTSR_ADDR_SOFT_TRIG))
                reg_rdata <= soft_trig_reg;
            else if (hit(reg_addr, CTSR_ADDR_IRQ_STATUS))
                reg_rdata <= {5'h00, irq_status_reg};
            else if (hit(reg_addr, CTSR_ADDR_IRQ_MASK))
                reg_rdata <= {5'h00, irq_mask_reg};
            else
                reg_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_offset_write;
        @(posedge sys_clk) disable iff (rst)
        clk_en && reg_wr && reg_addr == CTSR_ADDR_AVERAGING
            |=> offset_averaging_depth == $past(reg_wdata[6:4]);
    endproperty
    a_offset_write: assert property (p_offset_write)
        else $error("offset averaging depth not written");

    property p_linearity_write;
        @(posedge sys_clk) disable iff (rst)
        clk_en && reg_wr && reg_addr == CTSR_ADDR_AVERAGING
            |=> linearity_averaging_depth == $past(reg_wdata[2:0]);
    endproperty
    a_linearity_write: assert property (p_linearity_write)
        else $error("linearity averaging depth not written");

    property p_status_read_only;
        @(posedge sys_clk) disable iff (rst)
        clk_en && reg_wr && reg_addr == CTSR_ADDR_STATUS && !fg_event && !eng_restart
            |=> foreground_finished_flag_reg == $past(foreground_finished_flag_reg);
    endproperty
    a_status_read_only: assert property (p_status_read_only)
        else $error("status register changed by a write");

    property p_stop_resume;
        @(posedge sys_clk) disable iff (rst)
        clk_en && eng_bg_resumed && !stop_event |=> !stopped_reg;
    endproperty
    a_stop_resume: assert property (p_stop_resume)
        else $error("stopped flag did not clear on resume");

    property p_stop_no_bg;
        @(posedge sys_clk) disable iff (rst)
        clk_en && !eng_bg_enabled && eng_fg_skipped |=> stopped_reg ##1 1'b1;
    endproperty
    a_stop_no_bg: assert property (p_stop_no_bg)
        else $error("stopped flag not set after foreground without background");

    property p_foreground_finished_flag;
        @(posedge sys_clk) disable iff (rst)
        clk_en && fg_event |=> foreground_finished_flag_reg && stopped_reg == ($past(stop_event) || $past(stopped_reg)
            && !$past(eng_bg_resumed) && !$past(eng_restart));
    endproperty
    a_foreground_finished_flag: assert property (p_foreground_finished_flag)
        else $error("done flag not set after foreground end");

    property p_pin_low;
        @(posedge sys_clk) disable iff (rst)
        clk_en && pin_sel == CTSR_PIN_LOW |=> !status_output_pin;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("status pin not held low");

    property p_soft_source;
        @(posedge sys_clk) disable iff (rst)
        clk_en && !pin_config_reg[0] |=> calibration_trigger == $past(soft_trig_reg[0]);
    endproperty
    a_soft_source: assert property (p_soft_source)
        else $error("software trigger not routed");

    property p_pin_source;
        @(posedge sys_clk) disable iff (rst)
        clk_en && pin_config_reg[0] |=> calibration_trigger == $past(trig_pin_sync);
    endproperty
    a_pin_source: assert property (p_pin_source)
        else $error("trigger pin not routed");

    property p_sleep;
        @(posedge sys_clk) disable iff (rst)
        clk_en |=> converter_sleep == ($past(lp_trigger_mode) && calibration_trigger);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep does not follow the trigger");

    c_pin_trigger:  cover property (@(posedge sys_clk) disable iff (rst)
        pin_config_reg[0] && $rose(calibration_trigger));
    c_irq_raised:   cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
    c_stop_resume:  cover property (@(posedge sys_clk) disable iff (rst)
        stopped_reg ##[1:20] !stopped_reg);
endmodule : ctsr_regs

// >>> logic/ctsr_pkg.sv
// constants shared by the calibration trigger and status register block
package ctsr_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] CTSR_ADDR_AVERAGING   = 8'h68;
    localparam logic [7:0] CTSR_ADDR_STATUS      = 8'h6a;
    localparam logic [7:0] CTSR_ADDR_PIN_CONFIG  = 8'h6b;
    localparam logic [7:0] CTSR_ADDR_SOFT_TRIG   = 8'h6c;
    localparam logic [7:0] CTSR_ADDR_IRQ_STATUS  = 8'h70;
    localparam logic [7:0] CTSR_ADDR_IRQ_MASK    = 8'h71;
    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [7:0] CTSR_RST_AVERAGING    = 8'h61;
    localparam logic [7:0] CTSR_RST_PIN_CONFIG   = 8'h00;
    localparam logic [7:0] CTSR_RST_SOFT_TRIG    = 8'h01;
    localparam logic [2:0] CTSR_RST_IRQ_MASK     = 3'h0;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTSR_OFS_AVG_LSB   = 4;      // offset averaging depth [6:4]
    localparam int CTSR_OFS_AVG_MSB   = 6;
    localparam int CTSR_LIN_AVG_LSB   = 0;      // linearity averaging depth [2:0]
    localparam int CTSR_LIN_AVG_MSB   = 2;
    localparam int CTSR_STAT_CODE_LSB = 2;      // status code [4:2]
    localparam int CTSR_STOPPED_BIT   = 1;
    localparam int CTSR_FOREGROUND_FINISHED_FLAG_BIT   = 0;
    localparam int CTSR_SEL_LSB       = 1;      // status pin selector [2:1]
    localparam int CTSR_SEL_MSB       = 2;
    localparam int CTSR_TRIG_SRC_BIT  = 0;
    localparam int CTSR_SOFT_TRIG_BIT = 0;
    localparam int CTSR_IRQ_FG_BIT    = 0;      // interrupt event positions
    localparam int CTSR_IRQ_STOP_BIT  = 1;
    localparam int CTSR_IRQ_ALARM_BIT = 2;
    localparam int CTSR_SYNC_STAGES   = 2;
    // ****************************************************************
    // status pin sources
    // ****************************************************************
    typedef enum logic [1:0] {
        CTSR_PIN_FOREGROUND_FINISHED_FLAG = 2'h0,
        CTSR_PIN_STOPPED = 2'h1,
        CTSR_PIN_ALARM   = 2'h2,
        CTSR_PIN_LOW     = 2'h3
    } ctsr_pin_sel_t;
endpackage : ctsr_pkg

// >>> logic/ctsr_sync.sv
// two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
module ctsr_sync
    import ctsr_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // ****************************************************************
    // first stage is read only by the second
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ctsr_sync

// >>> tb/ctsr_host_model.sv
// host-side model that drives the calibration trigger pin
`timescale 1ns/1ns
module ctsr_host_model
(
    input  wire logic sys_clk,
    input  wire logic status_output_pin,
    output logic      trigger_input_pin
);
    // ****************************************************************
    // trigger pin driving
    // ****************************************************************
    // the pin idles high so that no calibration trigger is asked for
    initial trigger_input_pin = 1'b1;

    // the level changes just after a clock edge, as host logic would do it
    task automatic drive_trigger(input logic level);
        @(posedge sys_clk);
        trigger_input_pin <= level;
    endtask : drive_trigger
endmodule : ctsr_host_model

// >>> tb/test_calibration_trigger_status_regs.sv
// self-checking bench for the calibration trigger and status registers
`timescale 1ns/1ns
`define check(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end
module test_calibration_trigger_status_regs
    import ctsr_pkg::*;
;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam int EV_FIN = 0, EV_SKIP = 1, EV_HALT = 2, EV_RESUME = 3, EV_RESTART = 4;
    logic       sys_clk;
    logic       rst;
    logic       clk_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [2:0] eng_status_code;
    logic [4:0] ev;             // finished, skipped, halted, resumed, restart
    logic       eng_bg_enabled;
    logic       alarm_in;
    logic       lp_trigger_mode;
    logic       trigger_input_pin;
    logic       status_output_pin;
    logic       calibration_trigger;
    logic       converter_sleep;
    logic [2:0] offset_averaging_depth;
    logic [2:0] linearity_averaging_depth;
    logic       irq;
    int         mismatches;
    int         tests_run;

    ctsr_regs dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .eng_status_code(eng_status_code), .eng_fg_finished(ev[EV_FIN]),
        .eng_fg_skipped(ev[EV_SKIP]), .eng_bg_enabled(eng_bg_enabled),
        .eng_bg_halted(ev[EV_HALT]), .eng_bg_resumed(ev[EV_RESUME]),
        .eng_restart(ev[EV_RESTART]), .alarm_in(alarm_in), .lp_trigger_mode(lp_trigger_mode),
        .trigger_input_pin(trigger_input_pin), .status_output_pin(status_output_pin),
        .calibration_trigger(calibration_trigger), .converter_sleep(converter_sleep),
        .offset_averaging_depth(offset_averaging_depth),
        .linearity_averaging_depth(linearity_averaging_depth), .irq(irq));

    ctsr_host_model host (.sys_clk(sys_clk), .status_output_pin(status_output_pin),
        .trigger_input_pin(trigger_input_pin));

    // 125 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // bus and helper tasks
    // ****************************************************************
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data judged in the cycle after it
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        `check(what, exp, reg_rdata)
    endtask : rd_check

    // one-cycle engine event, then one edge for the flag to land
    task automatic pulse(input int i);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev    <= '0;
        @(posedge sys_clk);
    endtask : pulse

    // alarm level changes on a rising edge, like every other input
    task automatic set_alarm(input logic v);
        @(posedge sys_clk);
        alarm_in <= v;
    endtask : set_alarm

    // let n edges pass and step off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // values straight after reset, read-data lifetime, unmapped address
    task automatic test_reset();
        #1;
        `check("offset depth", 3'h6, offset_averaging_depth)
        `check("linearity depth", 3'h1, linearity_averaging_depth)
        `check("trigger", 1'b1, calibration_trigger)
        `check("status pin", 1'b0, status_output_pin)
        rd_check(8'h68, 8'h61, "averaging");
        settle(1);
        `check("rdata after read", 8'h00, reg_rdata)
        rd_check(8'h6b, 8'h00, "pin config");
        rd_check(8'h6c, 8'h01, "soft trigger");
        rd_check(8'h71, 8'h00, "irq mask");
        rd_check(8'h55, 8'h00, "unmapped");
        rd_check(8'h6a, 8'h00, "status");
    endtask : test_reset

    // averaging depths follow their fields, reserved bits kept at zero
    task automatic test_averaging();
        logic [7:0] vals [3];
        vals = '{8'h75, 8'h07, 8'h70};
        foreach (vals[i])
        begin
            wr(8'h68, vals[i]);
            #1;
            `check("offset depth", vals[i][6:4], offset_averaging_depth)
            `check("linearity depth", vals[i][2:0], linearity_averaging_depth)
            rd_check(8'h68, vals[i], "averaging");
        end
        // a write while the clock enable is low is not taken
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h68, 8'h61);
        clk_en <= 1'b1;
        settle(1);
        `check("frozen offset depth", 3'h7, offset_averaging_depth)
        `check("frozen linearity depth", 3'h0, linearity_averaging_depth)
    endtask : test_averaging

    // status flags set and clear on engine events, writes refused
    task automatic test_status();
        @(posedge sys_clk);
        eng_bg_enabled  <= 1'b1;
        eng_status_code <= 3'h5;
        pulse(EV_RESTART);
        pulse(EV_FIN);
        rd_check(8'h6a, 8'h15, "status done");
        wr(8'h6a, 8'hff);
        rd_check(8'h6a, 8'h15, "status after write");
        pulse(EV_HALT);
        rd_check(8'h6a, 8'h17, "status halted");
        pulse(EV_RESUME);
        rd_check(8'h6a, 8'h15, "status resumed");
        pulse(EV_RESTART);
        eng_bg_enabled <= 1'b0;
        pulse(EV_SKIP);
        rd_check(8'h6a, 8'h17, "status skipped");
    endtask : test_status

    // every status pin source, with done low, stopped high, alarm both ways
    task automatic test_pin_select();
        logic [1:0] s;
        pulse(EV_RESTART);
        eng_bg_enabled <= 1'b1;
        pulse(EV_HALT);
        for (int i = 0; i < 4; i++)
        begin
            s = 2'(i);
            wr(8'h6b, {5'h00, s, 1'b0});
            settle(1);
            `check("status pin", (s == 2'h1), status_output_pin)
            set_alarm(1'b1);
            settle(1);
            `check("status pin alarm", (s == 2'h1) || (s == 2'h2), status_output_pin)
            set_alarm(1'b0);
        end
    endtask : test_pin_select

    // trigger source selection and low-power sleep
    task automatic test_trigger();
        @(posedge sys_clk);
        lp_trigger_mode <= 1'b1;
        wr(8'h6c, 8'h00);
        settle(2);
        `check("trigger soft 0", 1'b0, calibration_trigger)
        `check("sleep", 1'b0, converter_sleep)
        host.drive_trigger(1'b1);
        settle(4);
        `check("trigger pin ignored", 1'b0, calibration_trigger)
        wr(8'h6c, 8'h01);
        settle(2);
        `check("trigger soft 1", 1'b1, calibration_trigger)
        `check("sleep", 1'b1, converter_sleep)
        host.drive_trigger(1'b0);
        wr(8'h6b, 8'h01);
        settle(4);
        `check("trigger pin 0", 1'b0, calibration_trigger)
        `check("sleep", 1'b0, converter_sleep)
        host.drive_trigger(1'b1);
        wr(8'h6c, 8'h00);
        settle(4);
        `check("trigger pin 1", 1'b1, calibration_trigger)
        // back to the quiet setting: software source, trigger held high
        wr(8'h6b, 8'h00);
        wr(8'h6c, 8'h01);
        lp_trigger_mode <= 1'b0;
        settle(2);
        `check("trigger quiet", 1'b1, calibration_trigger)
    endtask : test_trigger

    // sticky events, mask, write-one-to-clear and the irq level
    task automatic test_irq();
        wr(8'h70, 8'h07);
        rd_check(8'h70, 8'h00, "irq status cleared");
        pulse(EV_RESTART);
        pulse(EV_FIN);
        rd_check(8'h70, 8'h01, "irq status done");
        `check("irq masked", 1'b0, irq)
        wr(8'h71, 8'h01);
        settle(2);
        `check("irq raised", 1'b1, irq)
        rd_check(8'h71, 8'h01, "irq mask");
        wr(8'h70, 8'h01);
        settle(2);
        `check("irq cleared", 1'b0, irq)
        set_alarm(1'b1);
        rd_check(8'h70, 8'h04, "irq status alarm");
        `check("irq alarm masked", 1'b0, irq)
        wr(8'h71, 8'h04);
        settle(2);
        `check("irq alarm", 1'b1, irq)
        set_alarm(1'b0);
        wr(8'h70, 8'h04);
        settle(2);
        `check("irq alarm cleared", 1'b0, irq)
    endtask : test_irq

    // ****************************************************************
    // run control
    // ****************************************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // main sequence
    initial
    begin
        mismatches      = 0;
        tests_run       = 0;
        rst             = 1'b1;
        clk_en          = 1'b1;
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        eng_status_code = 3'h0;
        ev              = '0;
        eng_bg_enabled  = 1'b0;
        alarm_in        = 1'b0;
        lp_trigger_mode = 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_averaging();
        test_status();
        test_pin_select();
        test_trigger();
        test_irq();
        wrap_up();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end
endmodule : test_calibration_trigger_status_regs
